//--- hdl/plmf_host.sv
// The implementer's own choices: the address map and the strobed register port.
`timescale 1ns/100ps
`include "plmf_cfg.svh"
module plmf_host #(
	parameter int unsigned BIT_CYCLES     = `PLMF_CLK_HZ / `PLMF_BAUD,
	parameter int unsigned TIMEOUT_CYCLES =
		`PLMF_POLL_MS * (`PLMF_CLK_HZ / `PLMF_MS_PER_S),
	parameter int unsigned VERIFY_CYCLES  =
		`PLMF_VERIFY_MS * (`PLMF_CLK_HZ / `PLMF_MS_PER_S),
	parameter int unsigned GAP_CYCLES     =
		`PLMF_RESET_GAP_S * `PLMF_CLK_HZ,
	parameter bit          ODD_PARITY     = 1'b1
) (
	input  wire logic        ref_clk,
	input  wire logic        nrst,
	input  wire logic [3:0]  regAddr,
	input  wire logic [31:0] regWdata,
	input  wire logic        regWr,
	input  wire logic        regRd,
	output logic      [31:0] regRdata,
	input  wire logic        lineIn,
	output logic             lineOut,
	output logic             lineOe
);
	plmf_char_if ch ();

	plmf_char_tx #(
		.BIT_CYCLES (BIT_CYCLES),
		.ODD_PARITY (ODD_PARITY)
	) u_tx (
		.ref_clk (ref_clk),
		.nrst    (nrst),
		.ch      (ch.tx),
		.lineOut (lineOut)
	);

	plmf_char_rx #(
		.BIT_CYCLES (BIT_CYCLES),
		.ODD_PARITY (ODD_PARITY)
	) u_rx (
		.ref_clk (ref_clk),
		.nrst    (nrst),
		.ch      (ch.rx),
		.lineIn  (lineIn)
	);

	// ------------------------------------------------------------
	// check byte
	// ------------------------------------------------------------
	function automatic logic [7:0] crcStep(input logic [7:0] c,
		input logic [7:0] b);
		logic [7:0] r;
		r = c ^ b;
		for (int i = 0; i < `PLMF_DATA_BITS; i++) begin
			if (r[7])
				r = {r[6:0], 1'b0} ^ `PLMF_CRC_POLY;
			else
				r = {r[6:0], 1'b0};
		end
		return r;
	endfunction

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	plmf_pkg::main_state_t state_q, state_d;
	logic [2:0]  idx_q, idx_d;
	logic        sent_q, sent_d;
	logic [25:0] timer_q, timer_d;
	logic [23:0] vtimer_q, vtimer_d;
	logic [7:0]  crc_q, crc_d;
	logic [7:0]  rxBuf_q [5];
	logic [7:0]  rxBuf_d [5];
	logic        type_q, type_d;
	logic        verify_q, verify_d;
	logic        double_q, double_d;
	logic [4:0]  unit_q, unit_d;
	logic [15:0] arg_q, arg_d;
	logic        curType_q, curType_d;
	logic [15:0] curArg_q, curArg_d;
	logic        pass_q, pass_d;
	logic        checking_q, checking_d;
	logic [`PLMF_ST_BITS-1:0] stat_q, stat_d;
	logic [31:0] rdata_q, rdata_d;
	logic        oe_q, oe_d;
	logic [31:0] rxWord_q, rxWord_d;
	logic        startFrame;
	logic        finish;
	logic [7:0]  addrByte;
	logic [7:0]  txSel;
	logic [7:0]  rxCrc;
	logic        frameBad;

	assign regRdata = rdata_q;
	assign lineOe   = oe_q;
	assign ch.rxEn  = (state_q == plmf_pkg::MS_WAIT);
	assign ch.txByte = txSel;

	// type bit, zero multiplex bits, unit field
	assign addrByte = {curType_q, `PLMF_MUX_ZERO, unit_q};

	// fixed byte order of a frame
	always_comb begin
		case (idx_q)
		3'h0:    txSel = `PLMF_SYNC_HOST; // host sync
		3'h1:    txSel = addrByte;
		3'h2:    txSel = curArg_q[15:8]; // first byte high
		3'h3:    txSel = curArg_q[7:0];
		default: txSel = crc_q;
		endcase
	end

	// receive check over first four bytes
	assign rxCrc = crcStep(crcStep(crcStep(crcStep(`PLMF_CRC_INIT,
		rxBuf_q[0]), rxBuf_q[1]), rxBuf_q[2]), rxBuf_q[3]);

	// ------------------------------------------------------------
	// sequencer and registers
	// ------------------------------------------------------------
	always_comb begin
		state_d    = state_q;
		idx_d      = idx_q;
		sent_d     = sent_q;
		timer_d    = timer_q + 26'h0000001;
		vtimer_d   = vtimer_q + 24'h000001;
		crc_d      = crc_q;
		rxBuf_d    = rxBuf_q;
		type_d     = type_q;
		verify_d   = verify_q;
		double_d   = double_q;
		unit_d     = unit_q;
		arg_d      = arg_q;
		curType_d  = curType_q;
		curArg_d   = curArg_q;
		pass_d     = pass_q;
		checking_d = checking_q;
		stat_d     = stat_q;
		oe_d       = oe_q;
		rxWord_d   = rxWord_q;
		rdata_d    = 32'h00000000;
		ch.txStart = 1'b0;
		startFrame = 1'b0;
		finish     = 1'b0;
		frameBad   = 1'b0;

		if (regRd) begin
			case (regAddr)
			`PLMF_REG_CTRL: begin
				rdata_d[`PLMF_CTRL_TYPE]   = type_q;
				rdata_d[`PLMF_CTRL_VERIFY] = verify_q;
				rdata_d[`PLMF_CTRL_DOUBLE] = double_q;
				rdata_d[`PLMF_CTRL_UNIT]   = unit_q;
			end
			`PLMF_REG_ARG:  rdata_d[15:0] = arg_q;
			`PLMF_REG_STAT: rdata_d[`PLMF_ST_BITS-1:0] = stat_q;
			`PLMF_REG_RXD:  rdata_d = rxWord_q;
			default:        rdata_d = 32'h00000000;
			endcase
		end
		// settings frozen while a transfer runs
		if (regWr && state_q == plmf_pkg::MS_IDLE) begin
			if (regAddr == `PLMF_REG_ARG)
				arg_d = regWdata[15:0];
			if (regAddr == `PLMF_REG_CTRL) begin
				type_d   = regWdata[`PLMF_CTRL_TYPE];
				verify_d = regWdata[`PLMF_CTRL_VERIFY];
				double_d = regWdata[`PLMF_CTRL_DOUBLE];
				unit_d   = regWdata[`PLMF_CTRL_UNIT];
			end
		end

		case (state_q)
		plmf_pkg::MS_IDLE: begin
			timer_d  = timer_q;
			vtimer_d = vtimer_q;
			if (regWr && regAddr == `PLMF_REG_CTRL &&
				regWdata[`PLMF_CTRL_GO]) begin
				stat_d     = '0;
				stat_d[`PLMF_ST_BUSY] = 1'b1;
				curType_d  = regWdata[`PLMF_CTRL_TYPE];
				curArg_d   = regWdata[`PLMF_CTRL_TYPE] ? arg_q : 16'h0000;
				pass_d     = 1'b0;
				checking_d = 1'b0;
				vtimer_d   = 24'h000000;
				startFrame = 1'b1;
			end
		end
		plmf_pkg::MS_SEND: begin
			// frame sent back to back, well inside latency
			if (!sent_q && !ch.txBusy) begin
				ch.txStart = 1'b1;
				sent_d     = 1'b1;
			end else if (sent_q && !ch.txBusy) begin
				sent_d = 1'b0;
				if (idx_q == `PLMF_LAST_BYTE) begin
					oe_d    = 1'b0;
					idx_d   = 3'h0;
					state_d = plmf_pkg::MS_WAIT;
				end else begin
					// check built over first four bytes
					crc_d = crcStep(crc_q, txSel);
					idx_d = idx_q + 3'h1;
				end
			end
		end
		plmf_pkg::MS_WAIT: begin
			if (ch.rxValid) begin
				rxBuf_d[idx_q] = ch.rxByte;
				if (ch.rxParErr)
					stat_d[`PLMF_ST_PARERR] = 1'b1;
				if (ch.rxFrmErr)
					stat_d[`PLMF_ST_FRMERR] = 1'b1;
				if (idx_q == `PLMF_LAST_BYTE)
					state_d = plmf_pkg::MS_EVAL;
				else
					idx_d = idx_q + 3'h1;
			end else if (timer_q >= 26'(TIMEOUT_CYCLES - 1)) begin
				stat_d[`PLMF_ST_NORESP] = 1'b1;
				finish = 1'b1;
			end
		end
		plmf_pkg::MS_EVAL: begin
			if (rxCrc != rxBuf_q[4]) begin
				stat_d[`PLMF_ST_CRCERR] = 1'b1;
				frameBad = 1'b1;
			end
			if (rxBuf_q[0][6:0] != `PLMF_SYNC_ACK ||
				rxBuf_q[1] != addrByte) begin
				stat_d[`PLMF_ST_ADDRERR] = 1'b1;
				frameBad = 1'b1;
			end
			if (rxBuf_q[0][7]) begin
				stat_d[`PLMF_ST_ACKERR] = 1'b1;
				frameBad = 1'b1;
			end
			// command echo compared against what was sent
			if (curType_q == `PLMF_TYPE_CMD &&
				{rxBuf_q[2], rxBuf_q[3]} != curArg_q) begin
				stat_d[`PLMF_ST_ECHOERR] = 1'b1;
				frameBad = 1'b1;
			end
			rxWord_d = 32'h00000000;
			rxWord_d[`PLMF_RXD_ARG]  = {rxBuf_q[2], rxBuf_q[3]};
			rxWord_d[`PLMF_RXD_UNIT] = rxBuf_q[1][4:0];
			rxWord_d[`PLMF_RXD_TYPE] = rxBuf_q[1][7];
			if (checking_q &&
				vtimer_q > 24'(VERIFY_CYCLES - 1))
				stat_d[`PLMF_ST_VLATE] = 1'b1;
			if (curType_q == `PLMF_TYPE_CMD && double_q && !pass_q) begin
				pass_d  = 1'b1;
				state_d = plmf_pkg::MS_GAP;
			end else if (curType_q == `PLMF_TYPE_CMD && verify_q &&
				!frameBad && !stat_q[`PLMF_ST_PARERR] &&
				!stat_q[`PLMF_ST_FRMERR]) begin
				curType_d  = `PLMF_TYPE_MON;
				curArg_d   = 16'h0000;
				checking_d = 1'b1;
				startFrame = 1'b1;
			end else begin
				finish = 1'b1;
			end
		end
		plmf_pkg::MS_GAP: begin
			// second command five seconds after first
			if (timer_q >= 26'(GAP_CYCLES - 1)) begin
				vtimer_d   = 24'h000000;
				startFrame = 1'b1;
			end
		end
		default: begin
			finish = 1'b1;
		end
		endcase

		if (startFrame) begin
			idx_d   = 3'h0;
			sent_d  = 1'b0;
			crc_d   = `PLMF_CRC_INIT;
			timer_d = 26'h0000000;
			// driver on only while our frame goes out
			oe_d    = 1'b1;
			state_d = plmf_pkg::MS_SEND;
		end
		if (finish) begin
			stat_d[`PLMF_ST_BUSY] = 1'b0;
			stat_d[`PLMF_ST_DONE] = 1'b1;
			oe_d    = 1'b0;
			state_d = plmf_pkg::MS_IDLE;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			state_q    <= plmf_pkg::MS_IDLE;
			idx_q      <= 3'h0;
			sent_q     <= 1'b0;
			timer_q    <= 26'h0000000;
			vtimer_q   <= 24'h000000;
			crc_q      <= `PLMF_CRC_INIT;
			rxBuf_q    <= '{default: 8'h00};
			type_q     <= 1'b0;
			verify_q   <= 1'b0;
			double_q   <= 1'b0;
			unit_q     <= 5'h00;
			arg_q      <= 16'h0000;
			curType_q  <= 1'b0;
			curArg_q   <= 16'h0000;
			pass_q     <= 1'b0;
			checking_q <= 1'b0;
			stat_q     <= '0;
			rdata_q    <= 32'h00000000;
			oe_q       <= 1'b0;
			rxWord_q   <= 32'h00000000;
		end else begin
			state_q    <= state_d;
			idx_q      <= idx_d;
			sent_q     <= sent_d;
			timer_q    <= timer_d;
			vtimer_q   <= vtimer_d;
			crc_q      <= crc_d;
			rxBuf_q    <= rxBuf_d;
			type_q     <= type_d;
			verify_q   <= verify_d;
			double_q   <= double_d;
			unit_q     <= unit_d;
			arg_q      <= arg_d;
			curType_q  <= curType_d;
			curArg_q   <= curArg_d;
			pass_q     <= pass_d;
			checking_q <= checking_d;
			stat_q     <= stat_d;
			rdata_q    <= rdata_d;
			oe_q       <= oe_d;
			rxWord_q   <= rxWord_d;
		end
	end
endmodule

//--- hdl/plmf_cfg.svh
`ifndef PLMF_CFG_SVH
`define PLMF_CFG_SVH

// ----------------------------------------------------------------
// clock, line rate and protocol timing
// ----------------------------------------------------------------
`define PLMF_CLK_HZ       10000000
`define PLMF_BAUD         300
`define PLMF_POLL_MS      450
`define PLMF_VERIFY_MS    900
`define PLMF_LATENCY_MS   225
`define PLMF_RESET_GAP_S  5
`define PLMF_MS_PER_S     1000

// ----------------------------------------------------------------
// character and frame layout
// ----------------------------------------------------------------
`define PLMF_LAST_BIT     4'hA
`define PLMF_PAR_IDX      4'h8
`define PLMF_DATA_BITS    8
`define PLMF_LAST_BYTE    3'h4
`define PLMF_SYNC_HOST    8'h16
`define PLMF_SYNC_ACK     7'h06
`define PLMF_MUX_ZERO     2'h0
`define PLMF_CRC_INIT     8'h00
`define PLMF_CRC_POLY     8'h07
`define PLMF_TYPE_CMD     1'b1
`define PLMF_TYPE_MON     1'b0

// ----------------------------------------------------------------
// software register map and fields
// ----------------------------------------------------------------
`define PLMF_REG_CTRL     4'h0
`define PLMF_REG_ARG      4'h4
`define PLMF_REG_STAT     4'h8
`define PLMF_REG_RXD      4'hC
`define PLMF_CTRL_GO      0
`define PLMF_CTRL_TYPE    1
`define PLMF_CTRL_VERIFY  2
`define PLMF_CTRL_DOUBLE  3
`define PLMF_CTRL_UNIT    12:8
`define PLMF_ST_BUSY      0
`define PLMF_ST_DONE      1
`define PLMF_ST_NORESP    2
`define PLMF_ST_PARERR    3
`define PLMF_ST_CRCERR    4
`define PLMF_ST_ECHOERR   5
`define PLMF_ST_ACKERR    6
`define PLMF_ST_FRMERR    7
`define PLMF_ST_ADDRERR   8
`define PLMF_ST_VLATE     9
`define PLMF_ST_BITS      10
`define PLMF_RXD_ARG      15:0
`define PLMF_RXD_UNIT     20:16
`define PLMF_RXD_TYPE     23

`endif

//--- hdl/plmf_pkg.sv
package plmf_pkg;

	typedef enum logic [1:0] {
		TX_IDLE  = 2'b01,
		TX_SHIFT = 2'b10
	} tx_state_t;

	typedef enum logic [3:0] {
		RX_IDLE  = 4'b0001,
		RX_START = 4'b0010,
		RX_DATA  = 4'b0100,
		RX_STOP  = 4'b1000
	} rx_state_t;

	typedef enum logic [4:0] {
		MS_IDLE = 5'b00001,
		MS_SEND = 5'b00010,
		MS_WAIT = 5'b00100,
		MS_EVAL = 5'b01000,
		MS_GAP  = 5'b10000
	} main_state_t;

endpackage

//--- hdl/plmf_char_if.sv
`timescale 1ns/100ps
interface plmf_char_if;
	logic       txStart;
	logic [7:0] txByte;
	logic       txBusy;
	logic       rxEn;
	logic       rxValid;
	logic [7:0] rxByte;
	logic       rxParErr;
	logic       rxFrmErr;

	modport ctl (output txStart, txByte, rxEn,
		input txBusy, rxValid, rxByte, rxParErr, rxFrmErr);
	modport tx (input txStart, txByte, output txBusy);
	modport rx (input rxEn, output rxValid, rxByte, rxParErr, rxFrmErr);
endinterface

//--- hdl/plmf_char_tx.sv
`timescale 1ns/100ps
`include "plmf_cfg.svh"
module plmf_char_tx #(
	parameter int unsigned BIT_CYCLES = `PLMF_CLK_HZ / `PLMF_BAUD,
	parameter bit          ODD_PARITY = 1'b1
) (
	input  wire logic       ref_clk,
	input  wire logic       nrst,
	plmf_char_if.tx         ch,
	output logic            lineOut
);
	plmf_pkg::tx_state_t state_q, state_d;
	logic [15:0] cnt_q, cnt_d;
	logic [3:0]  bit_q, bit_d;
	logic [10:0] frame_q, frame_d;
	logic        out_q, out_d;
	logic        bitTick;

	// ------------------------------------------------------------
	// character shifter
	// ------------------------------------------------------------
	assign bitTick  = (cnt_q == 16'(BIT_CYCLES - 1));
	assign ch.txBusy = (state_q == plmf_pkg::TX_SHIFT);
	assign lineOut  = out_q;

	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		bit_d   = bit_q;
		frame_d = frame_q;
		out_d   = out_q;
		case (state_q)
		plmf_pkg::TX_IDLE: begin
			if (ch.txStart) begin
				// start, lsb first data, parity, stop
				// parity sense set at build time
				frame_d = {1'b1, ^ch.txByte ^ ODD_PARITY, ch.txByte, 1'b0};
				out_d   = 1'b0;
				cnt_d   = 16'h0000;
				bit_d   = 4'h0;
				state_d = plmf_pkg::TX_SHIFT;
			end
		end
		plmf_pkg::TX_SHIFT: begin
			if (bitTick) begin
				cnt_d = 16'h0000;
				if (bit_q == `PLMF_LAST_BIT) begin
					out_d   = 1'b1;
					state_d = plmf_pkg::TX_IDLE;
				end else begin
					bit_d   = bit_q + 4'h1;
					frame_d = {1'b1, frame_q[10:1]};
					out_d   = frame_q[1];
				end
			end else begin
				cnt_d = cnt_q + 16'h0001;
			end
		end
		default: begin
			state_d = plmf_pkg::TX_IDLE;
			out_d   = 1'b1;
		end
		endcase
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			state_q <= plmf_pkg::TX_IDLE;
			cnt_q   <= 16'h0000;
			bit_q   <= 4'h0;
			frame_q <= 11'h7FF;
			out_q   <= 1'b1;
		end else begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
			bit_q   <= bit_d;
			frame_q <= frame_d;
			out_q   <= out_d;
		end
	end
endmodule

//--- hdl/plmf_char_rx.sv
`timescale 1ns/100ps
`include "plmf_cfg.svh"
module plmf_char_rx #(
	parameter int unsigned BIT_CYCLES = `PLMF_CLK_HZ / `PLMF_BAUD,
	parameter bit          ODD_PARITY = 1'b1
) (
	input  wire logic       ref_clk,
	input  wire logic       nrst,
	plmf_char_if.rx         ch,
	input  wire logic       lineIn
);
	localparam int unsigned HALF_CYCLES = BIT_CYCLES / 2;

	plmf_pkg::rx_state_t state_q, state_d;
	logic [15:0] cnt_q, cnt_d;
	logic [3:0]  bit_q, bit_d;
	logic [8:0]  shift_q, shift_d;
	logic        valid_q, valid_d;
	logic [7:0]  byte_q, byte_d;
	logic        par_q, par_d;
	logic        frm_q, frm_d;
	logic        bitTick;

	// ------------------------------------------------------------
	// mid-bit sampler
	// ------------------------------------------------------------
	assign bitTick     = (cnt_q == 16'(BIT_CYCLES - 1));
	assign ch.rxValid  = valid_q;
	assign ch.rxByte   = byte_q;
	assign ch.rxParErr = par_q;
	assign ch.rxFrmErr = frm_q;

	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q + 16'h0001;
		bit_d   = bit_q;
		shift_d = shift_q;
		valid_d = 1'b0;
		byte_d  = byte_q;
		par_d   = par_q;
		frm_d   = frm_q;
		case (state_q)
		plmf_pkg::RX_IDLE: begin
			cnt_d = 16'h0000;
			if (ch.rxEn && !lineIn)
				state_d = plmf_pkg::RX_START;
		end
		plmf_pkg::RX_START: begin
			// glitch shorter than half a bit is dropped
			if (cnt_q == 16'(HALF_CYCLES - 1)) begin
				cnt_d   = 16'h0000;
				bit_d   = 4'h0;
				state_d = lineIn ? plmf_pkg::RX_IDLE : plmf_pkg::RX_DATA;
			end
		end
		plmf_pkg::RX_DATA: begin
			if (bitTick) begin
				cnt_d   = 16'h0000;
				shift_d = {lineIn, shift_q[8:1]};
				bit_d   = bit_q + 4'h1;
				if (bit_q == `PLMF_PAR_IDX)
					state_d = plmf_pkg::RX_STOP;
			end
		end
		plmf_pkg::RX_STOP: begin
			if (bitTick) begin
				valid_d = 1'b1;
				byte_d  = shift_q[7:0];
				par_d   = (^shift_q) != ODD_PARITY;
				frm_d   = !lineIn;
				state_d = plmf_pkg::RX_IDLE;
			end
		end
		default: state_d = plmf_pkg::RX_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			state_q <= plmf_pkg::RX_IDLE;
			cnt_q   <= 16'h0000;
			bit_q   <= 4'h0;
			shift_q <= 9'h000;
			valid_q <= 1'b0;
			byte_q  <= 8'h00;
			par_q   <= 1'b0;
			frm_q   <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
			bit_q   <= bit_d;
			shift_q <= shift_d;
			valid_q <= valid_d;
			byte_q  <= byte_d;
			par_q   <= par_d;
			frm_q   <= frm_d;
		end
	end
endmodule

//--- verification/plmf_host_props.sv
`timescale 1ns/100ps
module plmf_host_props #(
	parameter int unsigned BIT_CYCLES = 16
) (
	input  wire logic        ref_clk,
	input  wire logic        nrst,
	input  wire logic [3:0]  regAddr,
	input  wire logic [31:0] regWdata,
	input  wire logic        regWr,
	input  wire logic        regRd,
	input  wire logic [31:0] regRdata,
	input  wire logic        lineIn,
	input  wire logic        lineOut,
	input  wire logic        lineOe
);
	logic        lastOut_q;
	int unsigned runLen_q;
	int unsigned oeLen_q;

	// run lengths let bit widths be checked without long repetitions
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			lastOut_q <= 1'b1;
			runLen_q  <= 0;
			oeLen_q   <= 0;
		end else begin
			lastOut_q <= lineOut;
			runLen_q  <= (lineOut != lastOut_q) ? 1 : runLen_q + 1;
			oeLen_q   <= lineOe ? oeLen_q + 1 : 0;
		end
	end

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	a_rd_window: assert property (!$past(regRd) |-> regRdata == 32'h0)
		else $error("read data outside its cycle");
	a_idle_high: assert property (!lineOe |-> lineOut)
		else $error("line out low while undriven");
	a_bit_width: assert property (lineOe && lineOut && !lastOut_q |->
		runLen_q % BIT_CYCLES == 0) else $error("low run not whole bits");
	a_char_max: assert property (lineOe && !lineOut && !lastOut_q |->
		runLen_q < 10 * BIT_CYCLES) else $error("low run too long");
	a_stop_end: assert property ($fell(lineOe) |->
		$past(lineOut) && runLen_q >= BIT_CYCLES)
		else $error("frame ends before stop bit");
	a_frame_len: assert property ($fell(lineOe) |->
		oeLen_q >= 55 * BIT_CYCLES && oeLen_q <= 55 * BIT_CYCLES + 16)
		else $error("frame length wrong");
	a_oe_hold: assert property ($rose(lineOe) |-> lineOe [*8])
		else $error("driver enable glitch");
	a_start_soon: assert property ($rose(lineOe) |-> ##[0:2] !lineOut)
		else $error("no start bit after enable");

	c_frame: cover property ($fell(lineOe));
	c_stat: cover property (regRd && regAddr == 4'h8);
	c_go: cover property (regWr && regAddr == 4'h0 && regWdata[0]);
endmodule

bind plmf_host plmf_host_props #(.BIT_CYCLES(BIT_CYCLES)) u_props (
	.ref_clk(ref_clk), .nrst(nrst), .regAddr(regAddr),
	.regWdata(regWdata), .regWr(regWr), .regRd(regRd),
	.regRdata(regRdata), .lineIn(lineIn), .lineOut(lineOut),
	.lineOe(lineOe));

//--- verification/plmf_unit_model.sv
`timescale 1ns/100ps
module plmf_unit_model #(
	parameter int B   = 16,
	parameter bit ODD = 1'b1
) (
	input  wire logic       ref_clk,
	input  wire logic       lineIn,
	output logic            lineOut,
	output logic            lineOe,
	input  wire logic [4:0] myUnit,
	input  wire logic [2:0] errMode,
	input  wire logic [7:0] replyDly
);
	logic [7:0]  rx [5];
	logic [7:0]  a [5];
	logic [15:0] state;
	logic        pe;
	int          nCmd, tLast, tPrev;
	int          cyc = 0;

	always @(posedge ref_clk) cyc <= cyc + 1;

	function automatic logic [7:0] crc4(input logic [7:0] b0, b1, b2, b3);
		logic [7:0]  c;
		logic [31:0] w;
		c = 8'h00;
		w = {b0, b1, b2, b3};
		for (int j = 0; j < 32; j++) begin
			if (j % 8 == 0) c = c ^ w[31 - j -: 8];
			c = {c[6:0], 1'b0} ^ (c[7] ? 8'h07 : 8'h00);
		end
		return c;
	endfunction

	task automatic getc(output logic [7:0] b);
		logic p;
		do @(posedge ref_clk); while (lineIn !== 1'b0);
		repeat (B / 2) @(posedge ref_clk);
		for (int i = 0; i < 9; i++) begin
			repeat (B) @(posedge ref_clk);
			if (i < 8) b[i] = lineIn;
			else p = lineIn;
		end
		if ((^{b, p}) != ODD) pe = 1'b1;
		repeat (B) @(posedge ref_clk);
	endtask

	task automatic putc(input logic [7:0] b, input logic bad);
		logic [10:0] f;
		// bad flips the parity bit to provoke a receive error
		f = {1'b1, ^b ^ ODD ^ bad, b, 1'b0};
		for (int i = 0; i < 11; i++) begin
			lineOut <= f[i];
			repeat (B) @(posedge ref_clk);
		end
	endtask

	task automatic reply();
		a[0] = {pe || errMode == 3'h1, 7'h06};
		// address byte echoed, mode 5 corrupts it
		a[1] = rx[1] ^ {7'h00, errMode == 3'h5};
		if (rx[1][7]) begin
			{a[2], a[3]} = {rx[2], rx[3]};
			if (!pe) state = {rx[2], rx[3]};
			nCmd++;
		end else begin
			{a[2], a[3]} = state;
		end
		if (errMode == 3'h3) a[3] = ~a[3];
		a[4] = crc4(a[0], a[1], a[2], a[3]) ^ {7'h0, errMode == 3'h2};
		// wait past host stop bit so the reply never begins while the host still drives
		repeat (B + replyDly) @(posedge ref_clk);
		lineOe <= 1'b1;
		for (int k = 0; k < 5; k++) putc(a[k], errMode == 3'h4 && k == 2);
		lineOe <= 1'b0;
	endtask

	initial begin
		lineOut = 1'b1;
		lineOe = 1'b0;
		state = 16'h0;
		nCmd = 0;
		forever begin
			pe = 1'b0;
			getc(rx[0]);
			tPrev = tLast;
			tLast = cyc;
			for (int k = 1; k < 5; k++) getc(rx[k]);
			if (rx[1][4:0] == myUnit &&
				rx[4] == crc4(rx[0], rx[1], rx[2], rx[3]))
				reply();
		end
	end
endmodule

//--- verification/tb_party_line_message_framer.sv
`timescale 1ns/100ps
`define CHK(g, e) begin nTests++; if ((g) !== (e)) begin nFail++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_party_line_message_framer;
	localparam int unsigned B = 16;
	localparam int unsigned GAP = 3000;
	localparam logic [31:0] ST [6] = '{32'h2, 32'h42, 32'h12, 32'h22,
		32'hA, 32'h102};
	logic        ref_clk, nrst, regWr, regRd, rdSeen, uOut, uOe;
	logic [3:0]  regAddr;
	logic [31:0] regWdata, regRdata;
	logic        lineOut, lineOe;
	logic [2:0]  errMode;
	logic [7:0]  dly;
	logic [32:0] expQ [$];
	logic [32:0] e;
	logic [15:0] arg;
	logic [4:0]  unit;
	int          nFail, nTests, cyc, n0;
	integer      seed = 32'h93a7563d;
	// ----
	// pull-up wire shared by host and unit
	// ----
	wire         bus = lineOe ? lineOut : (uOe ? uOut : 1'b1);

	plmf_host #(.BIT_CYCLES(B), .TIMEOUT_CYCLES(2000), .VERIFY_CYCLES(4000),
		.GAP_CYCLES(GAP), .ODD_PARITY(1'b1)) dut_u (
		.ref_clk(ref_clk), .nrst(nrst), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd),
		.regRdata(regRdata), .lineIn(bus), .lineOut(lineOut),
		.lineOe(lineOe));
	plmf_unit_model #(.B(B), .ODD(1'b1)) u_unit (.ref_clk(ref_clk),
		.lineIn(bus), .lineOut(uOut), .lineOe(uOe), .myUnit(unit),
		.errMode(errMode), .replyDly(dly));

	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	task automatic stopTest();
		$display("tests=%0d fails=%0d", nTests, nFail);
		if (nFail == 0 && nTests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// read data judged one cycle after its strobe, oldest note first
	always @(posedge ref_clk) begin
		rdSeen <= regRd;
		cyc <= cyc + 1;
		if (rdSeen) begin
			e = expQ.pop_front();
			if (e[32]) `CHK(regRdata, e[31:0])
		end
		if (cyc == 60000) begin
			nFail++;
			stopTest();
		end
	end

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge ref_clk);
		regWr <= 1'b0;
		@(posedge ref_clk);
	endtask

	task automatic rd(input logic [3:0] a, input logic [32:0] x);
		regAddr <= a;
		regRd <= 1'b1;
		expQ.push_back(x);
		@(posedge ref_clk);
		regRd <= 1'b0;
		@(posedge ref_clk);
	endtask

	// f is {double, verify, type}; status polled, then checked
	task automatic run(input logic [4:0] u, input logic [2:0] f,
		input logic [15:0] a, input logic [31:0] st);
		int n;
		dly <= 8'(($random(seed) & 63) + 1);
		wr(4'h4, {16'h0, a});
		wr(4'h0, {19'h0, u, 4'h0, f, 1'b1});
		n = 0;
		do begin
			rd(4'h8, 33'h0);
			n++;
		end while (regRdata[0] !== 1'b0 && n < 5000);
		if (n == 5000) nFail++;
		rd(4'h8, {1'b1, st});
	endtask

	initial begin
		nrst = 1'b0;
		regWr = 1'b0;
		regRd = 1'b0;
		rdSeen = 1'b0;
		regAddr = 4'h0;
		regWdata = 32'h0;
		errMode = 3'h0;
		dly = 8'h01;
		cyc = 0;
		nFail = 0;
		nTests = 0;
		unit = 5'($random(seed));
		repeat (12) @(posedge ref_clk);
		nrst <= 1'b1;
		@(posedge ref_clk);
		for (int i = 0; i < 4; i++) rd(4'(i * 4), 33'h1_0000_0000);
		rd(4'h2, 33'h1_0000_0000);
		arg = 16'($random(seed));
		wr(4'h4, {16'hFFFF, arg});
		rd(4'h4, {17'h1_0000, arg});
		wr(4'h8, 32'hFFFF_FFFF);
		rd(4'h8, 33'h1_0000_0000);
		$display("registers done");
		for (int m = 0; m < 6; m++) begin
			errMode <= 3'(m);
			arg = 16'($random(seed));
			run(unit, 3'b001, arg, ST[m]);
			`CHK(u_unit.rx[0], 8'h16)
			`CHK(u_unit.rx[1], {3'b100, unit})
			`CHK({u_unit.rx[2], u_unit.rx[3]}, arg)
			`CHK(u_unit.rx[4], u_unit.crc4(8'h16, {3'b100, unit},
				arg[15:8], arg[7:0]))
			if (m == 0) rd(4'hC, {9'h100, 3'b100, unit, arg});
		end
		rd(4'h0, {1'b1, 19'h0, unit, 4'h0, 3'b001, 1'b0});
		$display("command modes done");
		errMode <= 3'h0;
		run(unit, 3'b000, 16'h0, 32'h2);
		`CHK({u_unit.rx[2], u_unit.rx[3]}, 16'h0)
		rd(4'hC, {9'h100, 3'b000, unit, arg});
		$display("monitor done");
		run(unit ^ 5'h01, 3'b001, arg, 32'h6);
		$display("timeout done");
		arg = 16'($random(seed));
		run(unit, 3'b011, arg, 32'h2);
		rd(4'hC, {9'h100, 3'b000, unit, arg});
		errMode <= 3'h1;
		run(unit, 3'b011, arg, 32'h42);
		`CHK(u_unit.rx[1][7], 1'b1)
		errMode <= 3'h0;
		$display("verify done");
		n0 = u_unit.nCmd;
		run(unit, 3'b101, arg, 32'h2);
		`CHK(u_unit.nCmd - n0, 2)
		`CHK(u_unit.tLast - u_unit.tPrev >= GAP, 1'b1)
		$display("double done");
		stopTest();
	end
endmodule
